// ---- i2c_host_model.sv ----
// serial host model: drives clock and data, samples the acknowledge
`timescale 1ns/100ps
module i2c_host_model (
   input  wire logic mclk,
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_drv
);
   // a third of one serial bit, well above the sampler's needs
   localparam int H = 8;

   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic start();
      sda_drv <= 1'b1;
      scl <= 1'b1;
      tick(H);
      sda_drv <= 1'b0;
      tick(H);
      scl <= 1'b0;
      tick(H);
   endtask

   // msb first, data moves only while the clock is low, ninth bit released
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic [8:0] s;
      s = {b, 1'b1};
      ack = 1'b1;
      for (int i = 8; i >= 0; i--) begin
         sda_drv <= s[i];
         tick(H);
         scl <= 1'b1;
         tick(H / 2);
         ack = sda_line;
         tick(H / 2);
         scl <= 1'b0;
         tick(H);
      end
   endtask

   task automatic stop();
      sda_drv <= 1'b0;
      tick(H);
      scl <= 1'b1;
      tick(H);
      sda_drv <= 1'b1;
      tick(H);
   endtask
endmodule

// ---- i2c_write_port.sv ----
// write-only serial slave: address match, register/data byte pairs, acknowledge
`timescale 1ns/100ps
module i2c_write_port
   import ledm_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   input  wire logic [1:0] addr_strap_i,
   output logic            sda_o,
   output logic            sda_oe_n,
   output logic            wr_stb,
   output logic [7:0]      wr_addr,
   output logic [7:0]      wr_data
);

   // ****************************************************************
   // bus event detection
   // ****************************************************************
   logic       scl_q;
   logic       sda_q;
   i2c_state_e state_r;
   i2c_state_e state_nxt;
   logic [3:0] bit_cnt_r;
   logic [7:0] shift_r;
   logic [1:0] strap_r;
   logic       strap_vld_r;

   wire scl_rise = scl_i & ~scl_q;
   wire scl_fall = ~scl_i & scl_q;
   wire start_c  = scl_i & scl_q & sda_q & ~sda_i;
   wire stop_c   = scl_i & scl_q & ~sda_q & sda_i;
   wire active_c = (state_r != I2C_IDLE);
   wire take_bit = active_c & scl_rise & (bit_cnt_r < BYTE_DONE);
   wire byte_end = active_c & scl_fall & (bit_cnt_r == BYTE_DONE);
   wire ack_end  = active_c & scl_fall & (bit_cnt_r == ACK_DONE);
   // read bit must be 0: the port only ever accepts writes
   wire addr_hit = (shift_r == {DEV_ADDR_HI, strap_r, 1'b0});

   // ****************************************************************
   // byte sequencing
   // ****************************************************************
   always_comb begin
      state_nxt = state_r;
      if (byte_end) begin
         unique case (state_r)
            I2C_IDLE : state_nxt = I2C_IDLE;
            I2C_ADDR : state_nxt = addr_hit ? I2C_REG : I2C_IDLE;
            I2C_REG  : state_nxt = I2C_DATA;
            I2C_DATA : state_nxt = I2C_REG;
         endcase
      end
   end

   // strap sampled once after reset release, never under the reset itself
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         strap_r     <= 2'h0;
         strap_vld_r <= 1'b0;
      end else if (!strap_vld_r) begin
         strap_r     <= addr_strap_i;
         strap_vld_r <= 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         scl_q     <= 1'b1;
         sda_q     <= 1'b1;
         state_r   <= I2C_IDLE;
         bit_cnt_r <= 4'h0;
         shift_r   <= 8'h00;
      end else begin
         scl_q <= scl_i;
         sda_q <= sda_i;
         if (start_c || stop_c) begin
            state_r   <= start_c ? I2C_ADDR : I2C_IDLE;
            bit_cnt_r <= 4'h0;
         end else begin
            state_r <= state_nxt;
            if (take_bit) begin
               shift_r   <= {shift_r[6:0], sda_i};
               bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (byte_end) begin
               bit_cnt_r <= ACK_DONE;
            end else if (ack_end) begin
               bit_cnt_r <= 4'h0;
            end
         end
      end
   end

   // ****************************************************************
   // acknowledge drive and write strobe
   // ****************************************************************
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sda_o    <= 1'b0;
         sda_oe_n <= 1'b1;
         wr_stb   <= 1'b0;
         wr_addr  <= 8'h00;
         wr_data  <= 8'h00;
      end else begin
         sda_o  <= 1'b0;
         wr_stb <= byte_end & (state_r == I2C_DATA);
         if (start_c || stop_c || ack_end) begin
            sda_oe_n <= 1'b1;
         end else if (byte_end) begin
            sda_oe_n <= (state_r == I2C_ADDR) & ~addr_hit;
         end
         if (byte_end && state_r == I2C_REG) begin
            wr_addr <= shift_r;
         end
         if (byte_end && state_r == I2C_DATA) begin
            wr_data <= shift_r;
         end
      end
   end

   addr_match_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (byte_end && state_r == I2C_ADDR && !start_c && !stop_c && !addr_hit)
      |=> (sda_oe_n && state_r == I2C_IDLE))
      else $error("foreign address acknowledged");

   data_strobe_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (byte_end && state_r == I2C_DATA && !start_c && !stop_c)
      |=> (wr_stb && !sda_oe_n && state_r == I2C_REG && wr_data == $past(shift_r)))
      else $error("data byte not strobed with acknowledge");

endmodule

// ---- led_matrix_scan_controller.sv ----
// top of the led matrix scan controller: registers, double buffer, scan outputs
`timescale 1ns/100ps
module led_matrix_scan_controller
   import ledm_pkg::*;
#(
   parameter int ON_CYCLES  = COL_ON_CYC,
   parameter int GAP_CYCLES = COL_GAP_CYC
)(
   input  wire logic                mclk,
   input  wire logic                rst_n,
   input  wire logic                scl_i,
   input  wire logic                sda_i,
   output logic                     sda_o,
   output logic                     sda_oe_n,
   input  wire logic [1:0]          addr_strap_i,
   input  wire logic [ROW_BITS-1:0] eq_rows_i,
   output logic [NUM_COLS-1:0]      column_sink_lines,
   output logic [ROW_BITS-1:0]      row_bits,
   output logic [3:0]               row_current_code,
   output logic [2:0]               input_gain_select,
   output logic                     audio_mod_en,
   output logic                     equalizer_mode_enable,
   output logic                     power_down_bit
);

   // ****************************************************************
   // serial write port
   // ****************************************************************
   logic       wr_stb;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;

   i2c_write_port u_port (
      .mclk         (mclk),
      .rst_n        (rst_n),
      .scl_i        (scl_i),
      .sda_i        (sda_i),
      .addr_strap_i (addr_strap_i),
      .sda_o        (sda_o),
      .sda_oe_n     (sda_oe_n),
      .wr_stb       (wr_stb),
      .wr_addr      (wr_addr),
      .wr_data      (wr_data)
   );

   // ****************************************************************
   // register decode
   // ****************************************************************
   logic [7:0]                   cfg_r;
   logic [7:0]                   light_r;
   logic                         eq_en_r;
   logic [NUM_COLS-1:0][7:0]     shadow_r;
   logic [NUM_COLS-1:0][7:0]     column_pattern_slots_r;

   wire cfg_we    = wr_stb & (wr_addr == REG_CONFIG);
   wire light_we  = wr_stb & (wr_addr == REG_LIGHT);
   wire eq_we     = wr_stb & (wr_addr == REG_EQ);
   // any other commit value is ignored, so a stray write cannot flip the picture
   wire commit_we = wr_stb & (wr_addr == REG_COMMIT) & (wr_data == COMMIT_KEY);

   // nothing here clears on shutdown, so the picture returns unchanged
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_r   <= CFG_RST;
         light_r <= LIGHT_RST;
         eq_en_r <= 1'b0;
      end else begin
         if (cfg_we) begin
            cfg_r <= wr_data;
         end
         if (light_we) begin
            light_r <= wr_data;
         end
         if (eq_we) begin
            eq_en_r <= wr_data[EQ_EN_BIT];
         end
      end
   end

   // ****************************************************************
   // double-buffered column patterns
   // ****************************************************************
   for (genvar c = 0; c < NUM_COLS; c++) begin : g_col
      wire slot_we = wr_stb & (wr_addr == 8'(REG_COL_FIRST + 8'(c)));
      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            shadow_r[c]               <= COL_RST;
            column_pattern_slots_r[c] <= COL_RST;
         end else begin
            if (slot_we) begin
               shadow_r[c] <= wr_data;
            end
            if (commit_we) begin
               column_pattern_slots_r[c] <= shadow_r[c];
            end
         end
      end
   end

   // ****************************************************************
   // geometry and scan time base
   // ****************************************************************
   logic [3:0] col_idx;
   logic       col_on;

   wire [1:0]          array_geometry_select = cfg_r[CFG_GEOM_HI:CFG_GEOM_LO];
   wire                pd_c       = cfg_r[CFG_PD_BIT];
   // 8x8, 7x9, 6x10, 5x11: one more column and one less row per step
   wire [3:0]          ncols      = 4'(EQ_COLS) + {2'b00, array_geometry_select};
   wire [ROW_BITS-1:0] row_mask   = ROW_MASK_FULL >> array_geometry_select;

   scan_timer #(
      .ON_CYCLES  (ON_CYCLES),
      .GAP_CYCLES (GAP_CYCLES)
   ) u_timer (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .ncols_i   (ncols),
      .col_idx_r (col_idx),
      .col_on_r  (col_on)
   );

   // ****************************************************************
   // output drive
   // ****************************************************************
   wire                in_geom  = (col_idx < ncols);
   wire                in_eq    = ~eq_en_r | (col_idx < 4'(EQ_COLS));
   wire                col_ok   = col_on & in_geom & in_eq & ~pd_c;
   wire [ROW_BITS-1:0] dot_rows = column_pattern_slots_r[col_idx];
   // band levels replace stored data while equalizer mode is on
   wire [ROW_BITS-1:0] src_rows = eq_en_r ? eq_rows_i : dot_rows;

   wire [NUM_COLS-1:0] col_nxt  = col_ok ? (NUM_COLS'(1) << col_idx) : '0;
   wire [ROW_BITS-1:0] row_nxt  = col_ok ? (src_rows & row_mask) : '0;
   // modulation only applies to dot modes; current code passes in both
   wire                aud_nxt  = cfg_r[CFG_AUDIO_BIT] & ~eq_en_r & ~pd_c;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         column_sink_lines     <= '0;
         row_bits              <= '0;
         row_current_code      <= LIGHT_RST[LIGHT_CUR_HI:LIGHT_CUR_LO];
         input_gain_select     <= LIGHT_RST[LIGHT_GAIN_HI:LIGHT_GAIN_LO];
         audio_mod_en          <= 1'b0;
         equalizer_mode_enable <= 1'b0;
         power_down_bit        <= 1'b0;
      end else begin
         column_sink_lines     <= col_nxt;
         row_bits              <= row_nxt;
         row_current_code      <= light_r[LIGHT_CUR_HI:LIGHT_CUR_LO];
         input_gain_select     <= light_r[LIGHT_GAIN_HI:LIGHT_GAIN_LO];
         audio_mod_en          <= aud_nxt;
         equalizer_mode_enable <= eq_en_r;
         power_down_bit        <= pd_c;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   shutdown_blank_a: assert property (@(posedge mclk) disable iff (!rst_n)
      pd_c |=> (column_sink_lines == '0 && row_bits == '0 && !audio_mod_en))
      else $error("array lit during shutdown");

   pd_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
      cfg_we |=> ##1 power_down_bit == $past(wr_data[CFG_PD_BIT], 2))
      else $error("power-down bit not taken from write");

   commit_copy_a: assert property (@(posedge mclk) disable iff (!rst_n)
      commit_we |=> column_pattern_slots_r == $past(shadow_r))
      else $error("commit did not copy shadow");

   shadow_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !commit_we |=> $stable(column_pattern_slots_r))
      else $error("active columns changed without commit");

   eq_cols_a: assert property (@(posedge mclk) disable iff (!rst_n)
      eq_en_r |=> column_sink_lines[NUM_COLS-1:EQ_COLS] == '0)
      else $error("high column driven in equalizer mode");

   row_mask_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (array_geometry_select == GEOM_5X11) |=> (row_bits & ~ROW_MASK_5X11) == '0)
      else $error("unused row lit in 5x11");

   geom_cols_a: assert property (@(posedge mclk) disable iff (!rst_n)
      1'b1 |=> (column_sink_lines >> $past(ncols)) == '0)
      else $error("column beyond geometry driven");

   dot_rows_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (col_ok && !eq_en_r) |=> row_bits == ($past(dot_rows) & $past(row_mask)))
      else $error("dot mode rows not from column data");

   eq_rows_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (col_ok && eq_en_r) |=> row_bits == ($past(eq_rows_i) & $past(row_mask)))
      else $error("equalizer rows not from band levels");

   rows_7x9_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (array_geometry_select == GEOM_7X9) |=> !row_bits[ROW_BITS-1])
      else $error("unused row lit in 7x9");

   rows_6x10_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (array_geometry_select == GEOM_6X10) |=> row_bits[ROW_BITS-1:ROW_BITS-2] == 2'h0)
      else $error("unused row lit in 6x10");

   // ****************************************************************
   // scan drive checks
   // ****************************************************************
   one_column_a: assert property (@(posedge mclk) disable iff (!rst_n)
      $onehot0(column_sink_lines))
      else $error("two columns driven at once");

   gap_dark_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !col_on |=> column_sink_lines == '0)
      else $error("column driven in the gap");

   col_scan_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (col_on && in_geom && in_eq && !pd_c) |=> column_sink_lines[$past(col_idx)])
      else $error("scanned column not driven");

   // settings are held through shutdown while not written, only the drive is blanked
   light_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (pd_c && !light_we && !$past(light_we)) |=> $stable(row_current_code))
      else $error("current setting lost in shutdown");

   // ****************************************************************
   // register to output paths: write, register, then output flop; column writes are checked at the shadow slot only
   // ****************************************************************
   sequence light_write_s;
      light_we;
   endsequence

   sequence eq_write_s;
      eq_we;
   endsequence

   sequence slot_write_s;
      wr_stb && wr_addr >= REG_COL_FIRST && wr_addr < REG_COMMIT;
   endsequence

   sequence dot_audio_s;
      cfg_r[CFG_AUDIO_BIT] && !eq_en_r && !pd_c;
   endsequence

   property cur_path_p;
      light_write_s |=> ##1 row_current_code == $past(wr_data[LIGHT_CUR_HI:LIGHT_CUR_LO], 2);
   endproperty

   property gain_path_p;
      light_write_s |=> ##1 input_gain_select == $past(wr_data[LIGHT_GAIN_HI:LIGHT_GAIN_LO], 2);
   endproperty

   property eq_path_p;
      eq_write_s |=> ##1 equalizer_mode_enable == $past(wr_data[EQ_EN_BIT], 2);
   endproperty

   property slot_path_p;
      slot_write_s |=> shadow_r[4'($past(wr_addr) - REG_COL_FIRST)] == $past(wr_data);
   endproperty

   cur_path_a: assert property (@(posedge mclk) disable iff (!rst_n) cur_path_p)
      else $error("row current not taken from write");

   gain_path_a: assert property (@(posedge mclk) disable iff (!rst_n) gain_path_p)
      else $error("gain not taken from write");

   eq_path_a: assert property (@(posedge mclk) disable iff (!rst_n) eq_path_p)
      else $error("equalizer enable not taken from write");

   slot_path_a: assert property (@(posedge mclk) disable iff (!rst_n) slot_path_p)
      else $error("column write missed its shadow slot");

   aud_on_a: assert property (@(posedge mclk) disable iff (!rst_n)
      dot_audio_s |=> audio_mod_en)
      else $error("audio modulation not applied");

   aud_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !cfg_r[CFG_AUDIO_BIT] |=> !audio_mod_en)
      else $error("audio modulation without enable");

endmodule

// ---- ledm_pkg.sv ----
// shared constants, register map and state codes for the led matrix scan controller
package ledm_pkg;

   // ****************************************************************
   // bus address and register map
   // ****************************************************************
   localparam logic [4:0] DEV_ADDR_HI   = 5'h18;
   localparam logic [7:0] REG_CONFIG    = 8'h00;
   localparam logic [7:0] REG_COL_FIRST = 8'h01;
   localparam logic [7:0] REG_COMMIT    = 8'h0C;
   localparam logic [7:0] REG_LIGHT     = 8'h0D;
   localparam logic [7:0] REG_EQ        = 8'h0F;
   localparam logic [7:0] COMMIT_KEY    = 8'h00;

   // ****************************************************************
   // field positions and reset values
   // ****************************************************************
   localparam int         CFG_PD_BIT    = 7;
   localparam int         CFG_AUDIO_BIT = 2;
   localparam int         CFG_GEOM_HI   = 1;
   localparam int         CFG_GEOM_LO   = 0;
   localparam int         LIGHT_CUR_HI  = 3;
   localparam int         LIGHT_CUR_LO  = 0;
   localparam int         LIGHT_GAIN_HI = 6;
   localparam int         LIGHT_GAIN_LO = 4;
   localparam int         EQ_EN_BIT     = 6;
   localparam logic [7:0] CFG_RST       = 8'h00;
   localparam logic [7:0] LIGHT_RST     = 8'h00;
   localparam logic [7:0] COL_RST       = 8'h00;
   localparam logic [7:0] ROW_MASK_FULL = 8'hFF;
   localparam logic [7:0] ROW_MASK_5X11 = 8'h1F;

   // ****************************************************************
   // array shape
   // ****************************************************************
   localparam int NUM_COLS = 11;
   localparam int EQ_COLS  = 8;
   localparam int ROW_BITS = 8;

   typedef enum logic [1:0] {
      GEOM_8X8  = 2'b00,
      GEOM_7X9  = 2'b01,
      GEOM_6X10 = 2'b10,
      GEOM_5X11 = 2'b11
   } geom_e;

   // ****************************************************************
   // scan timing
   // ****************************************************************
   localparam int CLK_MHZ     = 200;
   localparam int COL_ON_US   = 32;
   localparam int COL_GAP_US  = 1;
   localparam int COL_ON_CYC  = COL_ON_US * CLK_MHZ;
   localparam int COL_GAP_CYC = COL_GAP_US * CLK_MHZ;

   // ****************************************************************
   // serial port
   // ****************************************************************
   localparam logic [3:0] BYTE_DONE = 4'h8;
   localparam logic [3:0] ACK_DONE  = 4'h9;

   typedef enum logic [1:0] {
      I2C_IDLE = 2'b00,
      I2C_ADDR = 2'b01,
      I2C_REG  = 2'b10,
      I2C_DATA = 2'b11
   } i2c_state_e;

endpackage

// ---- scan_timer.sv ----
// free-running column scan time base: column on time, gap, wrap at column count
`timescale 1ns/100ps
module scan_timer
   import ledm_pkg::*;
#(
   parameter int ON_CYCLES  = COL_ON_CYC,
   parameter int GAP_CYCLES = COL_GAP_CYC,
   parameter int CNT_W      = 16
)(
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic [3:0] ncols_i,
   output logic [3:0]      col_idx_r,
   output logic            col_on_r
);

   if (ON_CYCLES < 1 || GAP_CYCLES < 1 || ON_CYCLES >= 2**CNT_W || GAP_CYCLES >= 2**CNT_W)
      $error("scan timer counts out of range");

   localparam logic [CNT_W-1:0] ON_LOAD  = CNT_W'(ON_CYCLES - 1);
   localparam logic [CNT_W-1:0] GAP_LOAD = CNT_W'(GAP_CYCLES - 1);

   logic [CNT_W-1:0] cnt_r;
   wire              last_c = (col_idx_r >= 4'(ncols_i - 4'h1));

   // runs from reset with no host help, so refresh never stalls
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r     <= ON_LOAD;
         col_on_r  <= 1'b1;
         col_idx_r <= 4'h0;
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
      end else if (col_on_r) begin
         cnt_r    <= GAP_LOAD;
         col_on_r <= 1'b0;
      end else begin
         cnt_r     <= ON_LOAD;
         col_on_r  <= 1'b1;
         col_idx_r <= last_c ? 4'h0 : col_idx_r + 4'h1;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   logic [CNT_W-1:0] on_run_r;
   logic [CNT_W-1:0] gap_run_r;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         on_run_r  <= '0;
         gap_run_r <= '0;
      end else begin
         on_run_r  <= col_on_r ? on_run_r + 1'b1 : '0;
         gap_run_r <= col_on_r ? '0 : gap_run_r + 1'b1;
      end
   end

   col_len_a: assert property (@(posedge mclk) disable iff (!rst_n)
      $fell(col_on_r) |-> on_run_r == CNT_W'(ON_CYCLES))
      else $error("column on time wrong");

   col_gap_a: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(col_on_r) |-> gap_run_r == CNT_W'(GAP_CYCLES))
      else $error("column gap wrong");

   frame_wrap_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ($rose(col_on_r) && col_idx_r == 4'h0 && $stable(ncols_i))
      |-> $past(col_idx_r) == 4'(ncols_i - 4'h1))
      else $error("frame wrapped at wrong column");

endmodule

// ---- testbench.sv ----
// self-checking testbench of the led matrix scan controller
`timescale 1ns/100ps
module testbench;
   import ledm_pkg::*;
   localparam int         ON     = 20;
   localparam int         GAP    = 4;
   localparam logic [7:0] LV [3] = '{8'h7E, 8'h07, 8'hE8};
   logic        mclk     = 1'b0;
   logic        rst_n    = 1'b0;
   logic [1:0]  strap    = 2'b00;
   logic [7:0]  eq_rows  = 8'h00;
   logic        scl;
   logic        host_sda;
   logic        sda_o;
   logic        sda_oe_n;
   wire         sda_line;
   logic [10:0] cols;
   logic [7:0]  rows;
   logic [3:0]  cur;
   logic [2:0]  gain;
   logic        aud;
   logic        eqm;
   logic        pd;
   int          n_errors = 0;
   int          compares = 0;

   always #2.5 mclk = ~mclk;
   // pull-up wire: low if either party pulls
   assign sda_line = host_sda & (sda_oe_n | sda_o);

   i2c_host_model h_u (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_drv(host_sda));

   led_matrix_scan_controller #(.ON_CYCLES(ON), .GAP_CYCLES(GAP)) dut_u (
      .mclk(mclk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
      .sda_oe_n(sda_oe_n), .addr_strap_i(strap), .eq_rows_i(eq_rows),
      .column_sink_lines(cols), .row_bits(rows), .row_current_code(cur),
      .input_gain_select(gain), .audio_mod_en(aud), .equalizer_mode_enable(eqm),
      .power_down_bit(pd));

   // ****************************************************************
   // tasks
   // ****************************************************************
   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic close_out();
      $display("compares %0d, n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic reset();
      rst_n <= 1'b0;
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (2) @(posedge mclk);
   endtask

   task automatic probe(input logic [7:0] ab, input logic exp);
      logic k;
      h_u.start();
      h_u.send_byte(ab, k);
      h_u.stop();
      chk("addr ack", 24'(exp), 24'(k));
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic k0;
      logic k1;
      logic k2;
      h_u.start();
      h_u.send_byte({DEV_ADDR_HI, strap, 1'b0}, k0);
      h_u.send_byte(a, k1);
      h_u.send_byte(d, k2);
      h_u.stop();
      chk("write acks", 24'h0, 24'({k0, k1, k2}));
      repeat (4) @(posedge mclk);
   endtask

   // columns seen, and rows lit while column 0 is driven
   task automatic observe(input int n, output logic [10:0] c, output logic [7:0] r);
      c = '0;
      r = '0;
      repeat (n) begin
         @(negedge mclk);
         c |= cols;
         if (cols[0]) r |= rows;
      end
   endtask

   task automatic wait_c0(input logic v, output int n);
      n = 0;
      while (cols[0] !== v && n < 5000) begin
         @(negedge mclk);
         n++;
      end
   endtask

   task automatic period(output int on, output int fr);
      int t;
      // leave the launching edge first, so cols is settled when read
      @(negedge mclk);
      wait_c0(1'b0, t);
      wait_c0(1'b1, t);
      wait_c0(1'b0, on);
      wait_c0(1'b1, t);
      fr = on + t;
   endtask

   // ****************************************************************
   // tests
   // ****************************************************************
   initial begin
      logic [10:0] c;
      logic [7:0]  r;
      int          on;
      int          fr;
      for (int s = 0; s < 4; s++) begin
         strap <= 2'(s);
         reset();
         probe({DEV_ADDR_HI, 2'(s), 1'b0}, 1'b0);
         probe({DEV_ADDR_HI, 2'(s ^ 1), 1'b0}, 1'b1);
         probe({DEV_ADDR_HI, 2'(s), 1'b1}, 1'b1);
      end
      $display("test address done");
      chk("reset outputs", 24'h0, 24'({cur, gain, aud, eqm, pd}));
      observe(300, c, r);
      chk("blank 8x8", 24'({11'h0FF, 8'h00}), 24'({c, r}));
      wr(REG_COL_FIRST, 8'hA5);
      observe(300, c, r);
      chk("shadow held", 24'h0, 24'(r));
      wr(REG_COMMIT, 8'h01);
      observe(300, c, r);
      chk("bad commit", 24'h0, 24'(r));
      wr(REG_COMMIT, COMMIT_KEY);
      observe(300, c, r);
      chk("committed", 24'hA5, 24'(r));
      $display("test shadow done");
      wr(REG_COL_FIRST, 8'hFF);
      wr(REG_COMMIT, COMMIT_KEY);
      for (int i = 0; i < 2; i++) begin
         wr(REG_CONFIG, 8'h80);
         observe(300, c, r);
         chk("shutdown", 24'({1'b1, 19'h0}), 24'({pd, c, r}));
         wr(REG_CONFIG, 8'h00);
         observe(300, c, r);
         chk("resume", 24'({1'b0, 11'h0FF, 8'hFF}), 24'({pd, c, r}));
      end
      $display("test shutdown done");
      for (int g = 0; g < 4; g++) begin
         wr(REG_CONFIG, 8'(g));
         period(on, fr);
         chk("column on", 24'(ON), 24'(on));
         chk("frame", 24'((8 + g) * (ON + GAP)), 24'(fr));
         observe(fr, c, r);
         chk("columns", 24'((1 << (8 + g)) - 1), 24'(c));
         chk("row mask", 24'(8'hFF >> g), 24'(r));
      end
      $display("test geometry done");
      eq_rows <= 8'h3C;
      wr(REG_CONFIG, 8'h07);
      chk("audio on", 24'h1, 24'(aud));
      wr(REG_EQ, 8'h40);
      observe(300, c, r);
      chk("eq scan", 24'({2'b10, 11'h0FF, 8'h1C}), 24'({eqm, aud, c, r}));
      for (int i = 0; i < 3; i++) begin
         wr(REG_LIGHT, LV[i]);
         chk("gain current", 24'(LV[i][6:0]), 24'({gain, cur}));
      end
      wr(REG_EQ, 8'hBF);
      observe(300, c, r);
      chk("eq off", 24'({2'b01, 11'h7FF, 8'h1F}), 24'({eqm, aud, c, r}));
      $display("test equalizer done");
      close_out();
   end

   // the whole run is near 22k cycles; this allows more than three times that
   initial begin
      #400_000;
      n_errors++;
      close_out();
   end
endmodule
